/* File: core/lfd_ahb_slave.sv */
// module: zero-wait AHB-Lite slave, single word transfers, always OKAY
// assumes: sole slave, hready is its own hreadyout
`timescale 1ns/100ps
module lfd_ahb_slave (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  lfd_reg_if.bus                    regs
);
  import lfd_pkg::*;
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr_q;
  logic              next_wr_pend;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0]       next_hrdata;
  logic              accept;

  always_comb begin
    accept       = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    next_wr_pend = accept && hwrite;
    next_wr_addr = accept ? haddr[ADDR_W-1:0] : wr_addr_q;
    next_hrdata  = (accept && !hwrite) ? regs.rd_data : hrdata;
  end

  // read data is sampled in the address phase so it stands from a flop
  assign regs.rd_addr = haddr[ADDR_W-1:0];
  assign regs.wr_en   = wr_pend;
  assign regs.wr_addr = wr_addr_q;
  assign regs.wr_data = hwdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr_q <= '0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr_q <= next_wr_addr;
      hrdata    <= next_hrdata;
    end
  end
endmodule : lfd_ahb_slave

/* File: core/lfd_core.sv */
// module: led driver fault check, thermal, reference short and power save
// assumes: pwm counter, shift framing and comparators live outside;
// pwm_on, period_first, pwm_data_load, pwm_latch_zero are on hclk
`timescale 1ns/100ps
module lfd_core (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 pwm_count_clock,
  input  wire logic                 shift_clock,
  input  wire logic                 load_strobe,
  input  wire logic                 pwm_data_load,
  input  wire logic                 pwm_latch_zero,
  input  wire logic                 period_first,
  input  wire logic                 blank,
  input  wire logic [lfd_pkg::NCH-1:0] pwm_on,
  input  wire logic [lfd_pkg::NCH-1:0] open_cmp,
  input  wire logic [lfd_pkg::NCH-1:0] short_cmp,
  input  wire logic [lfd_pkg::NCH-1:0] leak_cmp,
  input  wire logic                 ref_short_det,
  input  wire logic                 heat_warn_det,
  input  wire logic                 heat_cutoff,
  output logic      [lfd_pkg::NCH-1:0] output_channel,
  output logic                      check_sink_on,
  output logic      [2:0]           check_sink_current_level,
  output logic                      power_save_state,
  output logic                      overheat_error_flag,
  output logic                      heat_warning_flag,
  output logic                      ref_pin_short_flag
);
  import lfd_pkg::*;

  lfd_reg_if regs ();

  lfd_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (regs)
  );

  // pins: pwm count clock, shift clock, load strobe
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  lfd_sync #(.W(3)) u_pin_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   ({load_strobe, shift_clock, pwm_count_clock}),
    .level (pin_lvl),
    .rise  (pin_rise)
  );

  logic [3*NCH+2:0] ana_lvl;
  lfd_sync #(.W(3*NCH+3)) u_ana_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   ({heat_cutoff, heat_warn_det, ref_short_det, leak_cmp, short_cmp, open_cmp}),
    .level (ana_lvl),
    .rise  ()
  );

  logic [NCH-1:0] open_lvl;
  logic [NCH-1:0] short_lvl;
  logic [NCH-1:0] leak_lvl;
  logic           ref_lvl;
  logic           warn_lvl;
  logic           cutoff_lvl;
  logic           pwm_edge;
  logic           sclk_edge;
  logic           gs_lat;
  logic           first_edge;

  assign open_lvl   = ana_lvl[NCH-1:0];
  assign short_lvl  = ana_lvl[2*NCH-1:NCH];
  assign leak_lvl   = ana_lvl[3*NCH-1:2*NCH];
  assign ref_lvl    = ana_lvl[3*NCH];
  assign warn_lvl   = ana_lvl[3*NCH+1];
  assign cutoff_lvl = ana_lvl[3*NCH+2];
  assign pwm_edge   = pin_rise[0];
  assign sclk_edge  = pin_rise[1];
  assign gs_lat     = pin_rise[2] && pwm_data_load;
  assign first_edge = pwm_edge && period_first;

  // state
  logic           ctrl_icm;
  logic [1:0]     ctrl_cap;
  logic [1:0]     ctrl_psel;
  lfd_pwr_e       pwr;
  lfd_chk_e       chk;
  logic [7:0]     edge_cnt;
  logic           heat_off;
  logic [NCH-1:0] open_fault_flag;
  logic [NCH-1:0] short_fault_flag;
  logic [NCH-1:0] leak_fault_flag;

  logic           next_ctrl_icm;
  logic [2:0]     next_ctrl_lvl;
  logic [1:0]     next_ctrl_cap;
  logic [1:0]     next_ctrl_psel;
  lfd_pwr_e       next_pwr;
  lfd_chk_e       next_chk;
  logic [7:0]     next_edge_cnt;
  logic [7:0]     cap_edges;
  logic           capture_now;
  logic           ps_enabled;
  logic           next_heat_off;
  logic           next_overheat;
  logic           next_warn;
  logic           next_ref;
  logic           forced_off;
  logic [NCH-1:0] next_open;
  logic [NCH-1:0] next_short;
  logic [NCH-1:0] next_leak;
  logic [NCH-1:0] next_channel;
  logic [31:0]    rd_mux;

  // control register write
  always_comb begin
    next_ctrl_icm  = ctrl_icm;
    next_ctrl_lvl  = check_sink_current_level;
    next_ctrl_cap  = ctrl_cap;
    next_ctrl_psel = ctrl_psel;
    if (regs.wr_en && regs.wr_addr == OFS_CTRL) begin
      next_ctrl_icm  = regs.wr_data[CTL_ICM_BIT];
      next_ctrl_lvl  = regs.wr_data[CTL_LVL_LSB +: 3];
      next_ctrl_cap  = regs.wr_data[CTL_CAP_LSB +: 2];
      next_ctrl_psel = regs.wr_data[CTL_PSEL_LSB +: 2];
    end
  end

  // power save sequencing
  always_comb begin
    ps_enabled = (ctrl_psel != PSEL_OFF);
    next_pwr   = pwr;
    case (pwr)
      PWR_RUN: begin
        if (ps_enabled && (ctrl_psel == PSEL_WAKE_SCLK || ctrl_psel == PSEL_SLEEP_2)
            && gs_lat && pwm_latch_zero) begin
          next_pwr = PWR_SAVE;
        end
      end
      PWR_SAVE: begin
        if ((ctrl_psel == PSEL_WAKE_SCLK && sclk_edge) || !ps_enabled) begin
          next_pwr = PWR_RESUME;
        end
      end
      PWR_RESUME: begin
        if (first_edge) begin
          next_pwr = PWR_RUN;
        end
      end
      default: next_pwr = PWR_RUN;
    endcase
  end

  // period edge count and capture point
  always_comb begin
    case (ctrl_cap)
      2'h0:    cap_edges = CAP_EDGES_00;
      2'h1:    cap_edges = CAP_EDGES_01;
      2'h2:    cap_edges = CAP_EDGES_10;
      default: cap_edges = CAP_EDGES_11;
    endcase
    next_edge_cnt = edge_cnt;
    if (first_edge) begin
      next_edge_cnt = 8'h01;
    end else if (pwm_edge && edge_cnt != 8'hFF) begin
      next_edge_cnt = edge_cnt + 8'h01;
    end
    capture_now = pwm_edge && (next_edge_cnt == cap_edges);
  end

  // invisible check pulse
  always_comb begin
    next_chk = chk;
    case (chk)
      CHK_IDLE: begin
        if (ctrl_icm && pwr == PWR_RUN && next_pwr == PWR_RUN && first_edge) begin
          next_chk = CHK_PULSE;
        end
      end
      CHK_PULSE: begin
        if (capture_now || !ctrl_icm || next_pwr != PWR_RUN) begin
          next_chk = CHK_IDLE;
        end
      end
      default: next_chk = CHK_IDLE;
    endcase
  end

  // fault capture, thermal and reference short
  always_comb begin
    next_open  = open_fault_flag;
    next_short = short_fault_flag;
    if (capture_now) begin
      next_open  = open_lvl & (pwm_on | {NCH{chk == CHK_PULSE}});
      next_short = short_lvl & (pwm_on | {NCH{chk == CHK_PULSE}});
    end
    next_leak = leak_lvl & ~pwm_on & {NCH{~ctrl_icm}};
    next_ref  = ref_lvl;
    next_warn = warn_lvl ? 1'b1 : (gs_lat ? 1'b0 : heat_warning_flag);
    next_overheat = cutoff_lvl ? 1'b1 : (gs_lat ? 1'b0 : overheat_error_flag);
    next_heat_off = heat_off;
    if (cutoff_lvl) begin
      next_heat_off = 1'b1;
    end else if (heat_off && pwm_edge && !blank) begin
      next_heat_off = 1'b0;
    end
    forced_off   = next_ref || next_heat_off || next_pwr != PWR_RUN;
    next_channel = pwm_on & {NCH{~forced_off}};
  end

  // register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (regs.rd_addr)
      OFS_CTRL: begin
        rd_mux[CTL_ICM_BIT]       = ctrl_icm;
        rd_mux[CTL_LVL_LSB +: 3]  = check_sink_current_level;
        rd_mux[CTL_CAP_LSB +: 2]  = ctrl_cap;
        rd_mux[CTL_PSEL_LSB +: 2] = ctrl_psel;
      end
      OFS_STATUS: rd_mux[3:0] = {heat_off, check_sink_on, pwr == PWR_RESUME, power_save_state};
      OFS_FAULT_HI: begin
        rd_mux[FLT_OVERHEAT]  = overheat_error_flag;
        rd_mux[FLT_WARN]      = heat_warning_flag;
        rd_mux[FLT_REF_SHORT] = ref_pin_short_flag;
      end
      OFS_OPEN_SHORT: rd_mux = {short_fault_flag, open_fault_flag};
      OFS_LEAK: rd_mux[NCH-1:0] = leak_fault_flag;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  assign regs.rd_data = rd_mux;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_icm                 <= CTRL_RESET[CTL_ICM_BIT];
      check_sink_current_level <= CTRL_RESET[CTL_LVL_LSB +: 3];
      ctrl_cap                 <= CTRL_RESET[CTL_CAP_LSB +: 2];
      ctrl_psel                <= CTRL_RESET[CTL_PSEL_LSB +: 2];
      pwr                      <= PWR_RUN;
      chk                      <= CHK_IDLE;
      edge_cnt                 <= 8'h00;
      heat_off                 <= 1'b0;
      open_fault_flag          <= '0;
      short_fault_flag         <= '0;
      leak_fault_flag          <= '0;
      ref_pin_short_flag       <= 1'b0;
      heat_warning_flag        <= 1'b0;
      overheat_error_flag      <= 1'b0;
      output_channel           <= '0;
      check_sink_on            <= 1'b0;
      power_save_state         <= 1'b0;
    end else begin
      ctrl_icm                 <= next_ctrl_icm;
      check_sink_current_level <= next_ctrl_lvl;
      ctrl_cap                 <= next_ctrl_cap;
      ctrl_psel                <= next_ctrl_psel;
      pwr                      <= next_pwr;
      chk                      <= next_chk;
      edge_cnt                 <= next_edge_cnt;
      heat_off                 <= next_heat_off;
      open_fault_flag          <= next_open;
      short_fault_flag         <= next_short;
      leak_fault_flag          <= next_leak;
      ref_pin_short_flag       <= next_ref;
      heat_warning_flag        <= next_warn;
      overheat_error_flag      <= next_overheat;
      output_channel           <= next_channel;
      check_sink_on            <= (next_chk == CHK_PULSE);
      power_save_state         <= (next_pwr == PWR_SAVE);
    end
  end

  // checks
  sequence s_check_start;
    chk == CHK_IDLE && ctrl_icm && pwr == PWR_RUN && next_pwr == PWR_RUN && first_edge;
  endsequence
  sequence s_ps_wake;
    pwr == PWR_SAVE && ctrl_psel == PSEL_WAKE_SCLK && sclk_edge;
  endsequence

  AST_CHECK_START: assert property (@(posedge hclk) disable iff (!hresetn)
    s_check_start |=> check_sink_on) else $error("check pulse did not start");
  AST_CHECK_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    (chk == CHK_PULSE && capture_now) |=> !check_sink_on) else $error("check pulse not stopped");
  AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
    (capture_now && chk == CHK_PULSE) |=> open_fault_flag == $past(open_lvl)
      && short_fault_flag == $past(short_lvl)) else $error("fault capture wrong");
  AST_NO_CHECK_IN_SAVE: assert property (@(posedge hclk) disable iff (!hresetn)
    power_save_state |-> !check_sink_on) else $error("check pulse in power save");
  AST_REF_SHORT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_lvl |=> ref_pin_short_flag && output_channel == '0) else $error("ref short not forced");
  AST_PS_ENTER: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwr == PWR_RUN && gs_lat && pwm_latch_zero
     && (ctrl_psel == PSEL_WAKE_SCLK || ctrl_psel == PSEL_SLEEP_2))
    |=> power_save_state) else $error("power save not entered");
  AST_PS_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ps_wake |=> !power_save_state && output_channel == '0) else $error("power save exit wrong");
  AST_OVERHEAT: assert property (@(posedge hclk) disable iff (!hresetn)
    cutoff_lvl |=> overheat_error_flag && output_channel == '0) else $error("overheat not forced");
  AST_OVERHEAT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (gs_lat && !cutoff_lvl) |=> !overheat_error_flag) else $error("overheat flag kept");
  AST_WARN_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (gs_lat && !warn_lvl) |=> !heat_warning_flag) else $error("warning flag kept");
  AST_LEAK_IDM: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_icm |=> leak_fault_flag == '0) else $error("leak flag in check mode");
endmodule : lfd_core

/* File: core/lfd_sync.sv */
// module: three-flop synchroniser with agreement filter and rise pulse
// assumes: din is asynchronous to clk
`timescale 1ns/100ps
module lfd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_level;
  logic [W-1:0] next_rise;

  // a change counts once ff2 and ff3 agree
  always_comb begin
    next_level = (ff2 & ff3) | (level & (ff2 | ff3));
    next_rise  = next_level & ~level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1   <= '0;
      ff2   <= '0;
      ff3   <= '0;
      level <= '0;
      rise  <= '0;
    end else begin
      ff1   <= din;
      ff2   <= ff1;
      ff3   <= ff2;
      level <= next_level;
      rise  <= next_rise;
    end
  end
endmodule : lfd_sync

/* File: pkg/lfd_pkg.sv */
// package: constants, register map and state types of the led fault block
// assumes: one hclk domain, registers reached over an AHB-Lite slave
package lfd_pkg;
  localparam int          NCH            = 16;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_FAULT_HI   = 8'h08;
  localparam logic [7:0]  OFS_OPEN_SHORT = 8'h0C;
  localparam logic [7:0]  OFS_LEAK       = 8'h10;
  // control fields
  localparam int          CTL_ICM_BIT    = 0;
  localparam int          CTL_LVL_LSB    = 1;
  localparam int          CTL_CAP_LSB    = 4;
  localparam int          CTL_PSEL_LSB   = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  // readout bits 159:128 land in the fault word; flags at 151..149
  localparam int          FLT_OVERHEAT   = 151 - 128;
  localparam int          FLT_WARN       = 150 - 128;
  localparam int          FLT_REF_SHORT  = 149 - 128;
  // pwm count clock edges from period start to capture
  localparam logic [7:0]  CAP_EDGES_00   = 8'h02;
  localparam logic [7:0]  CAP_EDGES_01   = 8'h21;
  localparam logic [7:0]  CAP_EDGES_10   = 8'h41;
  localparam logic [7:0]  CAP_EDGES_11   = 8'h81;
  localparam logic [1:0]  PSEL_OFF       = 2'h0;
  localparam logic [1:0]  PSEL_WAKE_SCLK = 2'h1;
  localparam logic [1:0]  PSEL_SLEEP_2   = 2'h2;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

  typedef enum logic [2:0] {
    PWR_RUN    = 3'b001,
    PWR_SAVE   = 3'b010,
    PWR_RESUME = 3'b100
  } lfd_pwr_e;

  typedef enum logic [1:0] {
    CHK_IDLE  = 2'b01,
    CHK_PULSE = 2'b10
  } lfd_chk_e;
endpackage : lfd_pkg

/* File: pkg/lfd_reg_if.sv */
// interface: register access between the bus slave and the core
// assumes: all signals on hclk
`timescale 1ns/100ps
interface lfd_reg_if;
  import lfd_pkg::*;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  modport bus  (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport core (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : lfd_reg_if

/* File: tb/lfd_core_tb.sv */
// testbench: led fault block through its bus and pins
// assumes: zero-wait slave, pins seen about five hclk edges late
`timescale 1ns/100ps
module lfd_core_tb;
  import lfd_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic        pwm_data_load = 1'b0, pwm_latch_zero = 1'b0, period_first = 1'b0;
  logic        blank = 1'b0, ref_short_det = 1'b0, heat_warn_det = 1'b0, heat_cutoff = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [15:0] pwm_on = 16'hA5A5, open_cmp = 16'h0, short_cmp = 16'h0, leak_cmp = 16'h0;
  logic [15:0] output_channel;
  logic [2:0]  check_sink_current_level;
  logic        hreadyout, hresp, pcc, sck, lst, check_sink_on, power_save_state;
  logic        overheat_error_flag, heat_warning_flag, ref_pin_short_flag;
  int          errors = 0, tests_run = 0, cycles = 0;

  lfd_host_model u_lfd_host_model (.pwm_count_clock(pcc), .shift_clock(sck), .load_strobe(lst));

  lfd_core u_lfd_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_count_clock(pcc), .shift_clock(sck),
    .load_strobe(lst), .pwm_data_load(pwm_data_load), .pwm_latch_zero(pwm_latch_zero),
    .period_first(period_first), .blank(blank), .pwm_on(pwm_on), .open_cmp(open_cmp),
    .short_cmp(short_cmp), .leak_cmp(leak_cmp), .ref_short_det(ref_short_det),
    .heat_warn_det(heat_warn_det), .heat_cutoff(heat_cutoff), .output_channel(output_channel),
    .check_sink_on(check_sink_on), .check_sink_current_level(check_sink_current_level),
    .power_save_state(power_save_state), .overheat_error_flag(overheat_error_flag),
    .heat_warning_flag(heat_warning_flag), .ref_pin_short_flag(ref_pin_short_flag)
  );

  always #25 hclk = ~hclk;

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge hclk);
  endtask : cyc

  // single word transfer; address phase held until hready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  task automatic pwm_edge(input logic first);
    @(posedge hclk) period_first <= first;
    u_lfd_host_model.pulse(0);
    @(posedge hclk) period_first <= 1'b0;
    cyc(4);
  endtask : pwm_edge

  task automatic strobe(input logic pwm_write);
    @(posedge hclk) pwm_data_load <= pwm_write;
    u_lfd_host_model.pulse(2);
    @(posedge hclk) pwm_data_load <= 1'b0;
    cyc(4);
  endtask : strobe

  task automatic t_basic();
    rd(OFS_CTRL, 32'h0);
    rd(8'h14, 32'h0);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
    pwm_edge(1'b1);
    chk(output_channel, 16'hA5A5);
    @(posedge hclk) pwm_on <= 16'h5A5A;
    cyc(3);
    chk(output_channel, 16'h5A5A);
    @(posedge hclk) pwm_on <= 16'hA5A5;
    cyc(3);
  endtask : t_basic

  task automatic t_warn();
    @(posedge hclk) heat_warn_det <= 1'b1;
    cyc(8);
    chk({heat_warning_flag, output_channel}, {1'b1, 16'hA5A5});
    rd(OFS_FAULT_HI, 32'h0040_0000);
    @(posedge hclk) heat_warn_det <= 1'b0;
    cyc(8);
    strobe(1'b0);
    chk(heat_warning_flag, 1'b1);
    strobe(1'b1);
    chk(heat_warning_flag, 1'b0);
  endtask : t_warn

  task automatic t_heat();
    @(posedge hclk) heat_cutoff <= 1'b1;
    cyc(8);
    chk({overheat_error_flag, output_channel}, {1'b1, 16'h0});
    rd(OFS_FAULT_HI, 32'h0080_0000);
    rd(OFS_STATUS, 32'h0000_0008);
    @(posedge hclk) heat_cutoff <= 1'b0;
    blank <= 1'b1;
    cyc(8);
    chk(overheat_error_flag, 1'b1);
    pwm_edge(1'b0);
    chk(output_channel, 16'h0);
    strobe(1'b1);
    chk(overheat_error_flag, 1'b0);
    @(posedge hclk) blank <= 1'b0;
    pwm_edge(1'b0);
    chk(output_channel, 16'hA5A5);
  endtask : t_heat

  task automatic t_ref();
    @(posedge hclk) ref_short_det <= 1'b1;
    cyc(8);
    chk({ref_pin_short_flag, output_channel}, {1'b1, 16'h0});
    rd(OFS_FAULT_HI, 32'h0020_0000);
    @(posedge hclk) ref_short_det <= 1'b0;
    cyc(8);
    chk(ref_pin_short_flag, 1'b0);
    pwm_edge(1'b1);
  endtask : t_ref

  task automatic t_check();
    // link at 400 ns: 1 us is 2.5 periods, so capture select 01
    bus(1'b1, OFS_CTRL, 32'h0000_001B);
    @(posedge hclk) leak_cmp <= 16'hFFFF;
    open_cmp  <= 16'h00F0;
    short_cmp <= 16'h0F00;
    pwm_edge(1'b1);
    chk({check_sink_on, check_sink_current_level}, {1'b1, 3'h5});
    chk(output_channel, 16'hA5A5);
    rd(OFS_LEAK, 32'h0);
    repeat (31) pwm_edge(1'b0);
    chk(check_sink_on, 1'b1);
    pwm_edge(1'b0);
    chk(check_sink_on, 1'b0);
    rd(OFS_OPEN_SHORT, 32'h0F00_00F0);
    // longer capture select 10: nothing latched at edge 33
    bus(1'b1, OFS_CTRL, 32'h0000_002B);
    @(posedge hclk) open_cmp <= 16'h000F;
    short_cmp <= 16'hF000;
    pwm_edge(1'b1);
    repeat (63) pwm_edge(1'b0);
    chk(check_sink_on, 1'b1);
    rd(OFS_OPEN_SHORT, 32'h0F00_00F0);
    pwm_edge(1'b0);
    chk(check_sink_on, 1'b0);
    rd(OFS_OPEN_SHORT, 32'hF000_000F);
    bus(1'b1, OFS_CTRL, 32'h0);
    cyc(4);
    rd(OFS_LEAK, 32'h0000_5A5A);
  endtask : t_check

  task automatic t_save();
    @(posedge hclk) pwm_latch_zero <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, OFS_CTRL, 32'(p) << 6);
      strobe(1'b1);
      chk(power_save_state, 1'(p == 1 || p == 2));
      bus(1'b1, OFS_CTRL, 32'h0);
      pwm_edge(1'b1);
    end
    bus(1'b1, OFS_CTRL, 32'h0000_0041);
    strobe(1'b1);
    chk({power_save_state, output_channel}, {1'b1, 16'h0});
    rd(OFS_STATUS, 32'h0000_0001);
    pwm_edge(1'b1);
    chk(check_sink_on, 1'b0);
    u_lfd_host_model.pulse(1);
    cyc(4);
    chk(power_save_state, 1'b0);
    rd(OFS_STATUS, 32'h0000_0002);
    pwm_edge(1'b0);
    chk(output_channel, 16'h0);
    pwm_edge(1'b1);
    chk(output_channel, 16'hA5A5);
  endtask : t_save

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(4);
    t_basic();
    t_warn();
    t_heat();
    t_ref();
    t_check();
    t_save();
    conclude();
  end
endmodule : lfd_core_tb

/* File: tb/lfd_host_model.sv */
// partner: host side pins, pwm count clock, shift clock and load strobe
// assumes: pins are asynchronous to hclk and rest low between pulses
`timescale 1ns/100ps
module lfd_host_model (
  output logic pwm_count_clock,
  output logic shift_clock,
  output logic load_strobe
);
  logic [2:0] pins = 3'h0;

  assign pwm_count_clock = pins[0];
  assign shift_clock     = pins[1];
  assign load_strobe     = pins[2];

  // one 400 ns link period, odd offset keeps it off the hclk phase
  task automatic pulse(input int unsigned idx);
    #7;
    pins[idx] = 1'b1;
    #200;
    pins[idx] = 1'b0;
    #193;
  endtask : pulse
endmodule : lfd_host_model
